/* bench/mcs_stall_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_stall_ctrl_asserts (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic MA_VALID,
    input wire mcs_pkg::mcs_kind_e MA_KIND,
    input wire logic MA_SECOND,
    input wire logic IF_REQ,
    input wire logic MA_DONE,
    input wire logic MA_EXTENDED,
    input wire logic FETCH_GRANT,
    input wire logic SLOT_SPLIT,
    input wire logic MULT_BUSY
);
    import mcs_pkg::*;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    property p_lm; MA_DONE && $past(MA_KIND) == MCS_LONG_MAC && $past(MA_SECOND)
        |-> MULT_BUSY [*4]; endproperty
    a_lm: assert property (p_lm) else $error("long mac busy short");
    property p_xnd; MA_EXTENDED |-> !MA_DONE; endproperty
    a_xnd: assert property (p_xnd) else $error("stretched yet done");
    property p_xk; MA_EXTENDED |-> $past(MA_VALID) && $past(MA_SECOND)
        && $past(MA_KIND) != MCS_OTHER; endproperty
    a_xk: assert property (p_xk) else $error("stretch without mult access");
    property p_xend; MA_EXTENDED |-> ##[1:5] MA_DONE; endproperty
    a_xend: assert property (p_xend) else $error("stretch never ends");
    property p_dm; MA_DONE && $past(MA_KIND) == MCS_DMUL && $past(MA_SECOND)
        |-> MULT_BUSY; endproperty
    a_dm: assert property (p_dm) else $error("dmul skipped multiplier");
    property p_sk; SLOT_SPLIT |-> $past(IF_REQ) && $past(MA_KIND) == MCS_DMUL; endproperty
    a_sk: assert property (p_sk) else $error("split without fetch");
    property p_sd; SLOT_SPLIT |-> !MA_DONE ##1 (##[0:5] MA_DONE); endproperty
    a_sd: assert property (p_sd) else $error("split access lost");
endmodule
`default_nettype wire

/* bench/multiplier_contention_stall_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module multiplier_contention_stall_bench;
    import mcs_pkg::*;
    logic CLOCK = 0, SRST = 1, MA_VALID = 0, MA_SECOND = 0, IF_REQ = 0, busy = 0, xs;
    mcs_kind_e MA_KIND = MCS_OTHER;
    logic MA_DONE, MA_EXTENDED, FETCH_GRANT, SLOT_SPLIT, MULT_BUSY, st, sp, fg;
    int miscompares = 0, num_checks = 0, gap = 0, n;
    always #10 CLOCK = ~CLOCK;
    mcs_stall_ctrl dut (.CLOCK, .SRST, .MA_VALID, .MA_KIND, .MA_SECOND, .IF_REQ,
        .MA_DONE, .MA_EXTENDED, .FETCH_GRANT, .SLOT_SPLIT, .MULT_BUSY);
    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic seen, logic exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    // ----------------------------------------------------------------
    // Stimulus and model
    // ----------------------------------------------------------------
    task automatic op(mcs_kind_e kd, logic fr);
        MA_KIND = kd;
        MA_SECOND = kd != MCS_OTHER;
        IF_REQ = fr;
        MA_VALID = 1;
        xs = (kd == MCS_WORD_MAC || kd == MCS_DMUL) && busy && gap < 2;
        st = 0;
        sp = 0;
        fg = 0;
        n = 0;
        do begin
            @(posedge CLOCK);
            #1;
            st |= MA_EXTENDED === 1;
            sp |= SLOT_SPLIT === 1;
            fg |= SLOT_SPLIT === 1 && FETCH_GRANT === 1;
            n++;
        end while (MA_DONE !== 1 && n < 20);
        if (n == 20) begin
            miscompares++;
            stop_test;
        end
        MA_VALID = 0;
        IF_REQ = 0;
        chk("stall", st, xs);
        if (kd == MCS_DMUL && !xs) chk("split", sp, fr);
        if (kd == MCS_DMUL && !xs) chk("fetch grant", fg, fr);
        if (kd != MCS_OTHER) chk("mult start", MULT_BUSY, 1);
        if (kd == MCS_OTHER) gap++;
        else begin
            busy = 1;
            gap = 0;
        end
    endtask
    initial begin
        void'($urandom(32'h74F6));
        repeat (10) @(posedge CLOCK);
        #1 SRST = 0;
        for (int t = 0; t < 16; t++) begin
            op(MCS_LONG_MAC, 0);
            // Only 0 or 2 fillers: with one, the stall hangs on issue spacing
            repeat (2 * $urandom_range(1)) op(MCS_OTHER, 0);
            op($urandom_range(1) ? MCS_DMUL : MCS_WORD_MAC, 1'($urandom_range(1)));
            repeat (8) @(posedge CLOCK);
            #1 busy = 0;
            chk("mult busy", MULT_BUSY, 0);
        end
        stop_test;
    end
endmodule
bind mcs_stall_ctrl mcs_stall_ctrl_asserts u_chk (.CLOCK, .SRST, .MA_VALID, .MA_KIND,
    .MA_SECOND, .IF_REQ, .MA_DONE, .MA_EXTENDED, .FETCH_GRANT, .SLOT_SPLIT, .MULT_BUSY);
`default_nettype wire

/* design/mcs_busy_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module mcs_busy_counter #(
    parameter int CNT_W = mcs_pkg::MCS_CNT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [CNT_W-1:0] len,
    output logic busy,
    output logic [CNT_W-1:0] remaining
);
    import mcs_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } mcs_cnt_s;

    mcs_cnt_s r_q;
    mcs_cnt_s r_d;

    // ------------------------------------------------------------------
    // Occupancy count
    // ------------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        if (start) begin
            r_d.cnt = len;
        end else if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r_q.cnt <= CNT_W'(MCS_CNT_RST);
        end else begin
            r_q <= r_d;
        end
    end

    assign busy = (r_q.cnt != '0);
    assign remaining = r_q.cnt;

endmodule

`default_nettype wire

/* design/mcs_pkg.sv */
package mcs_pkg;

    // ------------------------------------------------------------------
    // Instruction kinds presented at the memory-access stage
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MCS_OTHER = 2'h0,
        MCS_LONG_MAC = 2'h1,
        MCS_WORD_MAC = 2'h2,
        MCS_DMUL = 2'h3
    } mcs_kind_e;

    // ------------------------------------------------------------------
    // Multiplier occupancy, in multiplier-busy-stage cycles
    // ------------------------------------------------------------------
    localparam int MCS_CNT_W = 3;
    localparam logic [MCS_CNT_W-1:0] MCS_LONG_MAC_CYC = 3'h4;
    localparam logic [MCS_CNT_W-1:0] MCS_WORD_MAC_CYC = 3'h2;
    localparam logic [MCS_CNT_W-1:0] MCS_DMUL_CYC = 3'h4;

    // Independent instructions that hide the multiplier contention
    localparam int MCS_GAP_W = 2;
    localparam logic [MCS_GAP_W-1:0] MCS_MIN_GAP = 2'h2;

    // Reset values
    localparam logic [MCS_CNT_W-1:0] MCS_CNT_RST = 3'h0;
    localparam logic [MCS_GAP_W-1:0] MCS_GAP_RST = 2'h0;

endpackage

/* design/mcs_stall_ctrl.sv */
// Contract
// - Word MAC second access meeting busy multiplier is stretched into one slot until free.
// - Two or more independent instructions after long MAC let word MAC go unstalled.
// - Signed double multiply owns a memory-access stage that reaches the multiplier.
// - Double multiply second access meeting busy multiplier is stretched until it frees.
// - Two or more independent instructions after long MAC remove double multiply stall.
// - Double multiply access contending with fetch splits the slot, fetch going first.
`timescale 1ns/1ps
`default_nettype none

module mcs_stall_ctrl (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic MA_VALID,
    input wire mcs_pkg::mcs_kind_e MA_KIND,
    input wire logic MA_SECOND,
    input wire logic IF_REQ,
    output logic MA_DONE,
    output logic MA_EXTENDED,
    output logic FETCH_GRANT,
    output logic SLOT_SPLIT,
    output logic MULT_BUSY
);
    import mcs_pkg::*;

    typedef struct packed {
        logic ma_done;
        logic extended;
        logic fetch_grant;
        logic split;
        logic split_done;
        logic mult_busy;
        logic [MCS_GAP_W-1:0] gap;
    } mcs_state_s;

    mcs_state_s r_q;
    mcs_state_s r_d;

    logic busy;
    logic mul_start;
    logic [MCS_CNT_W-1:0] mul_len;

    // ------------------------------------------------------------------
    // Multiplier occupancy
    // ------------------------------------------------------------------
    mcs_busy_counter #(
        .CNT_W(MCS_CNT_W)
    ) u_busy (
        .clk(CLOCK),
        .srst(SRST),
        .start(mul_start),
        .len(mul_len),
        .busy(busy),
        .remaining()
    );

    // ------------------------------------------------------------------
    // Access arbitration
    // ------------------------------------------------------------------
    logic req;
    logic mul_user;
    logic follower;
    logic contend;
    logic need_split;
    logic go;

    always_comb begin
        r_d = r_q;
        // A request already answered last cycle is still held by the
        // requester; ignore it so one access is never taken twice.
        req = MA_VALID && !r_q.ma_done;
        // Only the second access of a multiplier instruction uses it;
        // the double multiply always counts as such an access.
        mul_user = req && MA_KIND != MCS_OTHER && (MA_SECOND || MA_KIND == MCS_DMUL);
        follower = MA_KIND == MCS_WORD_MAC || MA_KIND == MCS_DMUL;
        contend = mul_user && follower && busy && (r_q.gap < MCS_MIN_GAP);
        need_split = mul_user && MA_KIND == MCS_DMUL && IF_REQ && !r_q.split_done;
        go = mul_user && !contend && !need_split;

        r_d.ma_done = go || (req && !mul_user);
        // Stretched access holds as a single slot until the multiplier frees
        r_d.extended = contend;
        r_d.fetch_grant = IF_REQ && !(go || (req && !mul_user));
        r_d.split = contend ? 1'b0 : need_split;
        if (need_split && !contend) begin
            r_d.split_done = 1'b1;
        end else if (go || !req) begin
            r_d.split_done = 1'b0;
        end

        // Independent instructions passing the access stage widen the gap
        if (go) begin
            r_d.gap = MCS_GAP_RST;
        end else if (req && !mul_user && r_q.gap != MCS_MIN_GAP) begin
            r_d.gap = r_q.gap + 1'b1;
        end

        mul_start = go;
        unique case (MA_KIND)
            MCS_LONG_MAC: mul_len = MCS_LONG_MAC_CYC;
            MCS_WORD_MAC: mul_len = MCS_WORD_MAC_CYC;
            MCS_DMUL: mul_len = MCS_DMUL_CYC;
            MCS_OTHER: mul_len = MCS_CNT_RST;
        endcase
        // Shown from the start cycle on, so the flag rises with MA_DONE, one cycle after the start
        r_d.mult_busy = go || busy;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            r_q.ma_done <= 1'b0;
            r_q.extended <= 1'b0;
            r_q.fetch_grant <= 1'b0;
            r_q.split <= 1'b0;
            r_q.split_done <= 1'b0;
            r_q.mult_busy <= 1'b0;
            r_q.gap <= MCS_GAP_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign MA_DONE = r_q.ma_done;
    assign MA_EXTENDED = r_q.extended;
    assign FETCH_GRANT = r_q.fetch_grant;
    assign SLOT_SPLIT = r_q.split;
    assign MULT_BUSY = r_q.mult_busy;

endmodule

`default_nettype wire
